// >>> verilog/pwm_protect_pkg.sv
/*
  Constants for the PWM fault, update-hold and trigger block.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package pwm_protect_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] FAULT_CFG_OFS = 8'h00;
  localparam logic [7:0] CONTROL_B_OFS = 8'h04;
  localparam logic [7:0] TRIG_CMP_OFS = 8'h08;
  localparam logic [7:0] PERIOD_OFS = 8'h0C;
  localparam logic [7:0] DUTY0_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h20;

  // ==========================================================
  // Field positions
  localparam int FAULT_EN_POS = 0;
  localparam int FAULT_MODE_POS = 1;
  localparam int FAULT_STAT_POS = 2;
  localparam int BREAK_EN_POS = 7;
  localparam int HOLD_POS = 1;
  localparam int DIR_POS = 3;
  localparam int POST_LSB = 4;

  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] FAULT_CFG_RST = 8'h00;
  localparam logic [7:0] CONTROL_B_RST = 8'h00;
  localparam logic [11:0] TRIG_CMP_RST = 12'h000;
  localparam logic [11:0] PERIOD_RST = 12'h000;
  localparam logic [13:0] DUTY_RST = 14'h0000;
  localparam int DUTY_COUNT = 4;
  localparam int CHANNELS = 6;

  // Time-base modes
  localparam logic [1:0] TB_FREE = 2'h0;
  localparam logic [1:0] TB_SINGLE = 2'h1;
  localparam logic [1:0] TB_UPDOWN = 2'h2;
  localparam logic [1:0] TB_UPDOWN_INT = 2'h3;

  typedef enum logic [2:0] {
    FLT_RUN = 3'b001,
    FLT_HOLD = 3'b010,
    FLT_WAIT = 3'b100
  } fault_state_t;

endpackage

// >>> verilog/trigger_postscale.sv
/*
  Special event trigger compare with postscaler.
  Assumes time-base count and direction are synchronous to mclk.
*/
`timescale 1ns/1ns
module trigger_postscale
  import pwm_protect_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] timebase_count,
  input wire logic count_down,
  input wire logic [1:0] timebase_mode,
  input wire logic [11:0] trigger_compare,
  input wire logic trigger_direction,
  input wire logic [3:0] trigger_postscale,
  input wire logic cmp_write,
  output logic trigger_pulse
);

  logic [3:0] post_reg;
  logic [3:0] post_next;
  logic pulse_reg;
  logic pulse_next;
  logic match;
  logic dir_ok;
  logic [11:0] last_reg;

  // ==========================================================
  // Compare
  always_comb begin
    if (timebase_mode == TB_UPDOWN || timebase_mode == TB_UPDOWN_INT) begin
      dir_ok = (count_down == trigger_direction); // R13
    end else begin
      dir_ok = 1'b1; // R14
    end
    // One hit per arrival at the compare value; always armed
    match = (timebase_count == trigger_compare) && (last_reg != timebase_count)
            && (trigger_compare != 12'h000) && dir_ok; // R12 R15 R16
  end

  // ==========================================================
  // Postscaler
  always_comb begin
    post_next = post_reg;
    pulse_next = 1'b0;
    if (cmp_write) begin
      post_next = 4'h0; // R18
    end else if (match) begin
      if (post_reg >= trigger_postscale) begin
        post_next = 4'h0;
        pulse_next = 1'b1; // R18
      end else begin
        post_next = post_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      post_reg <= 4'h0;
      pulse_reg <= 1'b0;
      last_reg <= 12'h000;
    end else begin
      post_reg <= post_next;
      pulse_reg <= pulse_next;
      last_reg <= timebase_count;
    end
  end

  assign trigger_pulse = pulse_reg;

endmodule

// >>> verilog/pwm_fault_lockout_trigger.sv
/*
  PWM protection: fault forcing, update hold, special event trigger, APB registers.
  Assumes the time base supplies count, direction, mode and period start,
  all synchronous to mclk; fault_in_n may be asynchronous.
*/
`timescale 1ns/1ns
// Functional notes
// (R1) Fault input is active low so open-drain sources can share it.
// (R2) Fault input acts only while the fault enable bit is set.
// (R3) Latched mode: outputs inactive until input high and status cleared.
// (R4) Latched mode: outputs resume at next period start after status clear.
// (R5) Cycle mode: inactive while low; resume and self-clear at next period.
// (R6) Status bit sets on asserted fault, reads zero when none.
// (R7) Software clears status in latched mode; hardware never does.
// (R8) Break-fault enable makes a debug breakpoint force the fault.
// (R9) Update hold blocks buffer-to-active transfer of duty and period.
// (R10) Releasing hold loads all pending buffers together.
// (R11) Software sets hold, writes buffers, then clears hold.
// (R12) Trigger pulse when time-base count equals trigger compare.
// (R13) Up/down mode: direction bit picks up or down phase.
// (R14) Direction bit ignored in other time-base modes.
// (R15) No trigger while compare value is zero.
// (R16) Trigger generation is always active, no enable.
// (R17) Forced inactive levels follow high and low side polarity.
// (R18) Postscaler 1:1 to 1:16, cleared on compare write or reset.
// (R19) Fault input passes a two-flop synchroniser first.
// (R20) Fault forcing overrides all upstream output logic.
module pwm_fault_lockout_trigger
  import pwm_protect_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_in_n,
  input wire logic debug_break,
  input wire logic high_side_polarity,
  input wire logic low_side_polarity,
  input wire logic [CHANNELS-1:0] pwm_raw,
  input wire logic [11:0] timebase_count,
  input wire logic count_down,
  input wire logic [1:0] timebase_mode,
  input wire logic period_start,
  output logic [CHANNELS-1:0] pwm_out,
  output logic [11:0] period_active,
  output logic [14*DUTY_COUNT-1:0] duty_active,
  output logic trigger_pulse
);

  // ==========================================================
  // State
  logic sync1_reg;
  logic sync2_reg;
  logic [7:0] fault_configuration_reg;
  logic [7:0] fault_configuration_next;
  logic [7:0] pwm_control_b_reg;
  logic [7:0] pwm_control_b_next;
  logic [11:0] trigger_compare_reg;
  logic [11:0] trigger_compare_next;
  logic [11:0] period_buf_reg;
  logic [11:0] period_buf_next;
  logic [11:0] period_value_reg;
  logic [11:0] period_value_next;
  logic [13:0] duty_buf_reg [DUTY_COUNT];
  logic [13:0] duty_buf_next [DUTY_COUNT];
  logic [13:0] duty_act_reg [DUTY_COUNT];
  logic [13:0] duty_act_next [DUTY_COUNT];
  fault_state_t fstate_reg;
  fault_state_t fstate_next;
  logic [CHANNELS-1:0] pwm_out_reg;
  logic [CHANNELS-1:0] pwm_out_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic cmp_write;
  logic fault_now;
  logic force_off;
  logic wr_go;
  logic rd_go;
  logic hit;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic logic duty_hit(input logic [7:0] a);
    duty_hit = (a >= DUTY0_OFS) && (a < DUTY0_OFS + 8'(4 * DUTY_COUNT)) && (a[1:0] == 2'b00);
  endfunction

  // Word index of a duty buffer within its block of offsets
  function automatic logic [1:0] duty_index(input logic [7:0] a);
    duty_index = 2'((a - DUTY0_OFS) >> 2);
  endfunction

  // ==========================================================
  // Fault synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= fault_in_n; // R19
      sync2_reg <= sync1_reg; // R19
    end
  end

  // ==========================================================
  // APB access
  // One wait state: the answer is registered from the access phase
  always_comb begin
    wr_go = psel && penable && pwrite && !pready_reg;
    rd_go = psel && penable && !pwrite && !pready_reg;
    hit = addr_is(paddr, FAULT_CFG_OFS) || addr_is(paddr, CONTROL_B_OFS)
          || addr_is(paddr, TRIG_CMP_OFS) || addr_is(paddr, PERIOD_OFS)
          || duty_hit(paddr) || addr_is(paddr, STATUS_OFS);
    pready_next = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !hit;
    cmp_write = wr_go && addr_is(paddr, TRIG_CMP_OFS);
    prdata_next = 32'h0000_0000;
    if (rd_go) begin
      if (addr_is(paddr, FAULT_CFG_OFS)) begin
        prdata_next = {24'h00_0000, fault_configuration_reg};
      end else if (addr_is(paddr, CONTROL_B_OFS)) begin
        prdata_next = {24'h00_0000, pwm_control_b_reg};
      end else if (addr_is(paddr, TRIG_CMP_OFS)) begin
        prdata_next = {20'h0_0000, trigger_compare_reg};
      end else if (addr_is(paddr, PERIOD_OFS)) begin
        prdata_next = {20'h0_0000, period_buf_reg};
      end else if (duty_hit(paddr)) begin
        prdata_next = {18'h0000, duty_buf_reg[duty_index(paddr)]};
      end else if (addr_is(paddr, STATUS_OFS)) begin
        prdata_next = {29'h000_0000, force_off, fstate_reg != FLT_RUN, sync2_reg};
      end
    end
  end

  // ==========================================================
  // Fault state and configuration
  always_comb begin
    fault_configuration_next = fault_configuration_reg;
    pwm_control_b_next = pwm_control_b_reg;
    trigger_compare_next = trigger_compare_reg;
    fstate_next = fstate_reg;
    fault_now = (!sync2_reg && fault_configuration_reg[FAULT_EN_POS]) // R1 R2
                || (debug_break && fault_configuration_reg[BREAK_EN_POS]); // R8
    if (wr_go && addr_is(paddr, FAULT_CFG_OFS)) begin
      fault_configuration_next[BREAK_EN_POS] = pwdata[BREAK_EN_POS];
      fault_configuration_next[FAULT_MODE_POS] = pwdata[FAULT_MODE_POS];
      fault_configuration_next[FAULT_EN_POS] = pwdata[FAULT_EN_POS];
      // Status is write-zero-to-clear only
      if (!pwdata[FAULT_STAT_POS]) begin
        fault_configuration_next[FAULT_STAT_POS] = 1'b0; // R7
      end
    end
    if (wr_go && addr_is(paddr, CONTROL_B_OFS)) begin
      pwm_control_b_next = pwdata[7:0] & 8'hFA;
    end
    if (cmp_write) begin
      trigger_compare_next = pwdata[11:0];
    end
    case (fstate_reg)
      FLT_RUN: begin
        if (fault_now) begin
          fstate_next = FLT_HOLD;
        end
      end
      FLT_HOLD: begin
        if (!fault_now) begin
          if (fault_configuration_reg[FAULT_MODE_POS]) begin
            fstate_next = FLT_WAIT; // R5
          end else if (!fault_configuration_next[FAULT_STAT_POS]) begin
            fstate_next = FLT_WAIT; // R3
          end
        end
      end
      // Outputs come back only on a period start, never mid-period
      FLT_WAIT: begin
        if (fault_now) begin
          fstate_next = FLT_HOLD;
        end else if (period_start) begin
          fstate_next = FLT_RUN; // R4 R5
          if (fault_configuration_reg[FAULT_MODE_POS]) begin
            fault_configuration_next[FAULT_STAT_POS] = 1'b0; // R5
          end
        end
      end
      default: fstate_next = FLT_RUN;
    endcase
    // Set wins over any clear in the same cycle
    if (fault_now) begin
      fault_configuration_next[FAULT_STAT_POS] = 1'b1; // R6
    end
    force_off = fault_now || (fstate_reg != FLT_RUN);
  end

  // ==========================================================
  // Output forcing with polarity
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (force_off) begin
        // Odd channels are high side; the inactive level equals the polarity bit
        pwm_out_next[i] = i[0] ? high_side_polarity : low_side_polarity; // R17 R20
      end else begin
        pwm_out_next[i] = pwm_raw[i];
      end
    end
  end

  // ==========================================================
  // Update hold buffers
  always_comb begin
    period_buf_next = period_buf_reg;
    period_value_next = period_value_reg;
    for (int d = 0; d < DUTY_COUNT; d++) begin
      duty_buf_next[d] = duty_buf_reg[d];
      duty_act_next[d] = duty_act_reg[d];
    end
    if (wr_go && addr_is(paddr, PERIOD_OFS)) begin
      period_buf_next = pwdata[11:0];
    end
    if (wr_go && duty_hit(paddr)) begin
      duty_buf_next[duty_index(paddr)] = pwdata[13:0];
    end
    // Actives track the buffers every cycle while the hold is clear
    if (!pwm_control_b_reg[HOLD_POS]) begin
      period_value_next = period_buf_reg; // R9 R10
      for (int d = 0; d < DUTY_COUNT; d++) begin
        duty_act_next[d] = duty_buf_reg[d]; // R10
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_configuration_reg <= FAULT_CFG_RST;
      pwm_control_b_reg <= CONTROL_B_RST;
      trigger_compare_reg <= TRIG_CMP_RST;
      period_buf_reg <= PERIOD_RST;
      period_value_reg <= PERIOD_RST;
      fstate_reg <= FLT_RUN;
      pwm_out_reg <= {CHANNELS{1'b0}};
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      for (int d = 0; d < DUTY_COUNT; d++) begin
        duty_buf_reg[d] <= DUTY_RST;
        duty_act_reg[d] <= DUTY_RST;
      end
    end else begin
      fault_configuration_reg <= fault_configuration_next;
      pwm_control_b_reg <= pwm_control_b_next;
      trigger_compare_reg <= trigger_compare_next;
      period_buf_reg <= period_buf_next;
      period_value_reg <= period_value_next;
      fstate_reg <= fstate_next;
      pwm_out_reg <= pwm_out_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      for (int d = 0; d < DUTY_COUNT; d++) begin
        duty_buf_reg[d] <= duty_buf_next[d];
        duty_act_reg[d] <= duty_act_next[d];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DUTY_COUNT; g++) begin : g_duty
      assign duty_active[14*g +: 14] = duty_act_reg[g];
    end
  endgenerate

  // ==========================================================
  // Special event trigger
  trigger_postscale u_trig (
    .mclk(mclk),
    .srst(srst),
    .timebase_count(timebase_count),
    .count_down(count_down),
    .timebase_mode(timebase_mode),
    .trigger_compare(trigger_compare_reg),
    .trigger_direction(pwm_control_b_reg[DIR_POS]),
    .trigger_postscale(pwm_control_b_reg[POST_LSB +: 4]),
    .cmp_write(cmp_write),
    .trigger_pulse(trigger_pulse)
  );

  assign pwm_out = pwm_out_reg;
  assign period_active = period_value_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// >>> tb/pwm_protect_chk.sv
/*
  Assertion checker for the PWM protection block.
  Bound to the top module; sees its ports only.
*/
`timescale 1ns/1ns
module pwm_protect_chk
  import pwm_protect_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_in_n,
  input wire logic debug_break,
  input wire logic high_side_polarity,
  input wire logic low_side_polarity,
  input wire logic [CHANNELS-1:0] pwm_raw,
  input wire logic [11:0] timebase_count,
  input wire logic count_down,
  input wire logic [1:0] timebase_mode,
  input wire logic [CHANNELS-1:0] pwm_out,
  input wire logic [11:0] period_active,
  input wire logic trigger_pulse
);
  // ======================================
  // Shadow copies of written registers
  logic [7:0] cfg_reg, cfg_next, ctl_reg, ctl_next;
  logic [11:0] cmp_reg, cmp_next;
  logic wr_hit;
  logic [CHANNELS-1:0] idle_lvl;
  assign wr_hit = psel && penable && pwrite && !pready;
  assign idle_lvl = {3{high_side_polarity, low_side_polarity}};
  always_comb begin
    cfg_next = cfg_reg;
    ctl_next = ctl_reg;
    cmp_next = cmp_reg;
    if (wr_hit && paddr == FAULT_CFG_OFS) cfg_next = pwdata[7:0];
    if (wr_hit && paddr == CONTROL_B_OFS) ctl_next = pwdata[7:0];
    if (wr_hit && paddr == TRIG_CMP_OFS) cmp_next = pwdata[11:0];
    if (srst) begin
      cfg_next = 8'h00;
      ctl_next = 8'h00;
      cmp_next = 12'h000;
    end
  end
  always_ff @(posedge mclk) begin
    cfg_reg <= cfg_next;
    ctl_reg <= ctl_next;
    cmp_reg <= cmp_next;
  end
  // ======================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (psel && penable && !pready && paddr > STATUS_OFS
    |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  a_fault_force: assert property ((!fault_in_n && cfg_reg[FAULT_EN_POS]) [*3]
    |=> pwm_out == idle_lvl) else $error("fault did not force outputs");
  a_break_force: assert property (debug_break && cfg_reg[BREAK_EN_POS]
    |=> pwm_out == idle_lvl) else $error("breakpoint did not force outputs");
  a_out_levels: assert property (!$past(srst) |-> pwm_out == $past(pwm_raw)
    || pwm_out == idle_lvl) else $error("output neither passed nor idle");
  a_trig_match: assert property (trigger_pulse |-> $past(timebase_count)
    == $past(cmp_reg) && $past(cmp_reg) != 12'h000) else $error("trigger off compare");
  a_trig_dir: assert property (trigger_pulse && $past(timebase_mode[1])
    |-> $past(count_down) == $past(ctl_reg[DIR_POS])) else $error("trigger wrong phase");
  a_hold_frozen: assert property (ctl_reg[HOLD_POS] |=> $stable(period_active))
    else $error("active period moved under hold");
endmodule

// >>> tb/timebase_model.sv
/*
  Time-base and upstream PWM model on the far side of the block.
  Assumes the block's active period sets the count span.
*/
`timescale 1ns/1ns
module timebase_model
  import pwm_protect_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [1:0] timebase_mode,
  input wire logic [11:0] period_active,
  output logic [11:0] timebase_count,
  output logic count_down,
  output logic period_start,
  output logic [CHANNELS-1:0] pwm_raw
);
  // ======================================
  // Counter, up/down in modes 2 and 3
  assign period_start = timebase_count == 12'h000;
  assign pwm_raw = {3{timebase_count[3], !timebase_count[3]}};
  always_ff @(posedge mclk) begin
    if (srst || period_active == 12'h000) begin
      timebase_count <= 12'h000;
      count_down <= 1'b0;
    end else if (!timebase_mode[1]) begin
      timebase_count <= (timebase_count >= period_active) ? 12'h000 : timebase_count + 12'h001;
      count_down <= 1'b0;
    end else if (count_down) begin
      timebase_count <= timebase_count - 12'h001;
      count_down <= timebase_count > 12'h001;
    end else begin
      timebase_count <= timebase_count + ((timebase_count >= period_active) ? 12'hFFF : 12'h001);
      count_down <= timebase_count >= period_active;
    end
  end
endmodule

// >>> tb/pwm_fault_lockout_trigger_tb.sv
/*
  Self-checking bench for the PWM protection block.
  Assumes the time-base model drives count, direction and period start.
*/
`timescale 1ns/1ns
module pwm_fault_lockout_trigger_tb
  import pwm_protect_pkg::*;
();
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, fault_in_n, debug_break;
  logic count_down, period_start, trigger_pulse, last_err, high_side_polarity, low_side_polarity;
  logic [1:0] timebase_mode;
  logic [7:0] paddr, pulses, a;
  logic [11:0] timebase_count, period_active;
  logic [31:0] pwdata, prdata, rdata;
  logic [CHANNELS-1:0] pwm_raw, pwm_out;
  logic [14*DUTY_COUNT-1:0] duty_active;
  logic [31:0] trig_cases [7] = '{32'h2000_0A10, 32'h2080_0A10, 32'h2180_0A08,
    32'h0F80_0A01, 32'h3080_0A10, 32'h2000_0000, 32'h1080_0A10};
  int err_count = 0;
  int checks_done = 0;
  pwm_fault_lockout_trigger i_pwm_fault_lockout_trigger (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_in_n(fault_in_n), .debug_break(debug_break),
    .high_side_polarity(high_side_polarity), .low_side_polarity(low_side_polarity),
    .pwm_raw(pwm_raw),
    .timebase_count(timebase_count), .count_down(count_down), .timebase_mode(timebase_mode),
    .period_start(period_start), .pwm_out(pwm_out), .period_active(period_active),
    .duty_active(duty_active), .trigger_pulse(trigger_pulse));
  timebase_model i_timebase_model (.mclk(mclk), .srst(srst), .timebase_mode(timebase_mode),
    .period_active(period_active), .timebase_count(timebase_count), .count_down(count_down),
    .period_start(period_start), .pwm_raw(pwm_raw));
  always #2 mclk = ~mclk;
  // ======================================
  // Tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(ad, 1'b0, 32'h0);
    check({32'h0, rdata}, {32'h0, exp});
  endtask
  task automatic forced(input logic [CHANNELS-1:0] exp);
    check({58'h0, pwm_out}, {58'h0, exp});
  endtask
  task automatic wait_period;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
      if (trigger_pulse === 1'b1) pulses++;
    end while (period_start !== 1'b1 && k < 400);
    if (k >= 400) err_count++;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ======================================
  // Tests
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_in_n = 1'b1;
    debug_break = 1'b0;
    high_side_polarity = 1'b1;
    low_side_polarity = 1'b0;
    timebase_mode = TB_UPDOWN;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(FAULT_CFG_OFS, 32'h0);
    rd(CONTROL_B_OFS, 32'h0);
    rd(8'h24, 32'h0);
    check({63'h0, last_err}, 64'h1);
    wr(PERIOD_OFS, 32'h28);
    check({52'h0, period_active}, 64'h28);
    wr(CONTROL_B_OFS, 32'h2);
    for (a = DUTY0_OFS; a < STATUS_OFS; a += 8'h04) wr(a, {24'h0, a});
    wr(PERIOD_OFS, 32'h30);
    check({52'h0, period_active}, 64'h28);
    check({8'h0, duty_active}, 64'h0);
    wr(CONTROL_B_OFS, 32'h0);
    check({8'h0, duty_active}, {8'h0, 14'h1C, 14'h18, 14'h14, 14'h10});
    check({52'h0, period_active}, 64'h30);
    $display("test registers finished");
    fault_in_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(STATUS_OFS, 32'h0);
    fault_in_n <= 1'b1;
    wr(FAULT_CFG_OFS, 32'h1);
    fault_in_n <= 1'b0;
    repeat (4) @(posedge mclk);
    forced(6'h2A);
    rd(FAULT_CFG_OFS, 32'h5);
    fault_in_n <= 1'b1;
    wait_period();
    repeat (3) @(posedge mclk);
    rd(FAULT_CFG_OFS, 32'h5);
    forced(6'h2A);
    wr(FAULT_CFG_OFS, 32'h1);
    rd(STATUS_OFS, 32'h7);
    wait_period();
    @(posedge mclk);
    rd(STATUS_OFS, 32'h1);
    wr(FAULT_CFG_OFS, 32'h3);
    fault_in_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(STATUS_OFS, 32'h6);
    rd(FAULT_CFG_OFS, 32'h7);
    fault_in_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wait_period();
    repeat (2) @(posedge mclk);
    rd(FAULT_CFG_OFS, 32'h3);
    rd(STATUS_OFS, 32'h1);
    $display("test fault finished");
    high_side_polarity <= 1'b0;
    low_side_polarity <= 1'b1;
    wr(FAULT_CFG_OFS, 32'h82);
    debug_break <= 1'b1;
    repeat (2) @(posedge mclk);
    forced(6'h15);
    rd(FAULT_CFG_OFS, 32'h86);
    debug_break <= 1'b0;
    repeat (3) @(posedge mclk);
    wait_period();
    repeat (2) @(posedge mclk);
    wr(FAULT_CFG_OFS, 32'h0);
    debug_break <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(STATUS_OFS, 32'h1);
    debug_break <= 1'b0;
    $display("test breakpoint finished");
    foreach (trig_cases[i]) begin
      timebase_mode <= trig_cases[i][29:28];
      wr(CONTROL_B_OFS, {24'h0, trig_cases[i][27:20]});
      wr(TRIG_CMP_OFS, {20'h0, trig_cases[i][19:8]});
      wait_period();
      pulses = 8'h00;
      repeat (16) wait_period();
      check({56'h0, pulses}, {56'h0, trig_cases[i][7:0]});
    end
    $display("test trigger finished");
    report_and_stop();
  end
endmodule
bind pwm_fault_lockout_trigger pwm_protect_chk i_pwm_protect_chk (.mclk(mclk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in_n(fault_in_n),
  .debug_break(debug_break), .high_side_polarity(high_side_polarity),
  .low_side_polarity(low_side_polarity), .pwm_raw(pwm_raw), .timebase_count(timebase_count),
  .count_down(count_down), .timebase_mode(timebase_mode), .pwm_out(pwm_out),
  .period_active(period_active), .trigger_pulse(trigger_pulse));
